/* File: uart_host_dma_pkg.sv */
// Purpose: shared constants and carriers for the host-side emulation register and dma block
// Assumes: host offsets are three-bit, processor i/o locations decode the low address byte
// Notes:   reset values of the divisor and scratch bytes are zero
package uart_host_dma_pkg;

	////////////////////////////////////////////////////////////////////////////////////////////
	// host offsets
	localparam logic [2:0] HOST_OFS_DIV_LOW  = 3'h0;
	localparam logic [2:0] HOST_OFS_DIV_HIGH = 3'h1;
	localparam logic [2:0] HOST_OFS_SCRATCH  = 3'h7;

	// processor i/o locations, low address byte
	localparam logic [7:0] PROC_OFS_SCRATCH  = 8'hf7;
	localparam logic [7:0] PROC_OFS_DIV_LOW  = 8'hf8;
	localparam logic [7:0] PROC_OFS_DIV_HIGH = 8'hf9;

	// reset values
	localparam logic [7:0] RST_DIV_LOW  = 8'h00;
	localparam logic [7:0] RST_DIV_HIGH = 8'h00;
	localparam logic [7:0] RST_SCRATCH  = 8'h00;

	// master control field positions
	localparam int MCR_SWAP_BIT = 3;
	localparam int MCR_RX_BIT   = 4;
	localparam int MCR_TX_BIT   = 5;
	// fifo control field position of the dma mode select
	localparam int FCR_DMA_MODE_BIT = 3;
	// line control field position of the divisor access bit
	localparam int LCR_DIV_ACCESS_BIT = 7;

	// transmitter timer, in clock cycles
	localparam int TX_DELAY_CYCLES = 16;

	////////////////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic tx_empty;
		logic tx_full;
		logic rx_empty;
		logic rx_at_trigger;
	} fifo_status_type;

	typedef struct packed {
		logic host_dir;
		logic host_ready_n;
	} host_dma_type;

endpackage

/* File: uart_host_dma.sv */
// Purpose: host-facing scratch and divisor registers plus host and processor dma requests
// Assumes: all inputs synchronous to clk_i; ce_i low freezes every flop
// Notes:   transmit, receive and interrupt-enable registers live outside; this block only
//          says when the host may reach them
`timescale 1ns/100ps

module uart_host_dma #(
	parameter int TX_DELAY = uart_host_dma_pkg::TX_DELAY_CYCLES
) (
	// clock, reset, enable
	input  wire logic                              clk_i,
	input  wire logic                              reset_i,
	input  wire logic                              ce_i,
	// host register port
	input  wire logic [2:0]                        host_addr_i,
	input  wire logic                              host_wr_i,
	input  wire logic                              host_rd_i,
	input  wire logic [7:0]                        host_wdata_i,
	output logic      [7:0]                        host_rdata_o,
	output logic                                   host_hit_o,
	output logic                                   host_uart_access_o,
	// emulated uart control copies
	input  wire logic [7:0]                        line_control_i,
	input  wire logic [7:0]                        master_control_i,
	input  wire logic [7:0]                        fifo_control_reg_i,
	// processor read port
	input  wire logic [7:0]                        proc_addr_i,
	input  wire logic                              proc_rd_i,
	output logic      [7:0]                        proc_rdata_o,
	output logic                                   divisor_irq_o,
	// status sources
	input  wire logic                              tx_holding_empty_shadow_i,
	input  wire logic                              tx_timer_en_i,
	input  wire logic                              rx_data_ready_i,
	input  wire logic                              rx_data_ready_shadow_i,
	input  wire logic                              rx_timer_en_i,
	input  wire uart_host_dma_pkg::fifo_status_type fifo_status_i,
	output logic                                   tx_holding_empty_o,
	// host dma
	output logic                                   host_tx_ready_n_o,
	output logic                                   host_rx_ready_n_o,
	output logic                                   host_tx_dma_req_o,
	output logic                                   host_rx_dma_req_o,
	// processor dma requests
	input  wire logic                              proc_dma_request_0_n_i,
	input  wire logic                              proc_dma_request_1_n_i,
	output logic                                   proc_dma_request_0_n_o,
	output logic                                   proc_dma_request_1_n_o
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// parameter check
	if (TX_DELAY < 1 || TX_DELAY > 65535) begin : g_bad_delay
		$error("TX_DELAY must lie in 1..65535");
	end

	localparam logic [15:0] DELAY_LAST = 16'(TX_DELAY - 1);

	////////////////////////////////////////////////////////////////////////////////////////////
	// decode
	logic       div_access;
	logic       tx_en;
	logic       rx_en;
	logic       swap;
	logic       multi_mode;
	logic       host_div_low;
	logic       host_div_high;
	logic       host_scratch;

	assign div_access    = line_control_i[uart_host_dma_pkg::LCR_DIV_ACCESS_BIT];
	assign tx_en         = master_control_i[uart_host_dma_pkg::MCR_TX_BIT];
	assign rx_en         = master_control_i[uart_host_dma_pkg::MCR_RX_BIT];
	assign swap          = master_control_i[uart_host_dma_pkg::MCR_SWAP_BIT];
	assign multi_mode    = fifo_control_reg_i[uart_host_dma_pkg::FCR_DMA_MODE_BIT];
	assign host_div_low  = div_access && host_addr_i == uart_host_dma_pkg::HOST_OFS_DIV_LOW;
	assign host_div_high = div_access && host_addr_i == uart_host_dma_pkg::HOST_OFS_DIV_HIGH;
	assign host_scratch  = host_addr_i == uart_host_dma_pkg::HOST_OFS_SCRATCH;
	assign host_hit_o    = host_div_low || host_div_high || host_scratch;
	// with the divisor access bit set, offsets 0 and 1 go to the divisor instead of the data and enable registers
	assign host_uart_access_o = !host_hit_o;

	////////////////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] div_low_ff;
	logic [7:0] div_high_ff;
	logic [7:0] scratch_ff;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_low_ff <= uart_host_dma_pkg::RST_DIV_LOW;
		end else if (ce_i && host_wr_i && host_div_low) begin
			div_low_ff <= host_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_high_ff <= uart_host_dma_pkg::RST_DIV_HIGH;
		end else if (ce_i && host_wr_i && host_div_high) begin
			div_high_ff <= host_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			scratch_ff <= uart_host_dma_pkg::RST_SCRATCH;
		end else if (ce_i && host_wr_i && host_scratch) begin
			scratch_ff <= host_wdata_i;
		end
	end

	// scratch writes deliberately left out: firmware never needs to know
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			divisor_irq_o <= 1'b0;
		end else if (ce_i) begin
			divisor_irq_o <= host_wr_i && (host_div_low || host_div_high);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// read ports
	logic [7:0] nxt_host_rdata;
	logic [7:0] nxt_proc_rdata;

	always_comb begin
		nxt_host_rdata = 8'h00;
		if (host_div_low) begin
			nxt_host_rdata = div_low_ff;
		end else if (host_div_high) begin
			nxt_host_rdata = div_high_ff;
		end else if (host_scratch) begin
			nxt_host_rdata = scratch_ff;
		end
	end

	always_comb begin
		unique case (proc_addr_i)
			uart_host_dma_pkg::PROC_OFS_SCRATCH:  nxt_proc_rdata = scratch_ff;
			uart_host_dma_pkg::PROC_OFS_DIV_LOW:  nxt_proc_rdata = div_low_ff;
			uart_host_dma_pkg::PROC_OFS_DIV_HIGH: nxt_proc_rdata = div_high_ff;
			default:                              nxt_proc_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			host_rdata_o <= 8'h00;
		end else if (ce_i && host_rd_i) begin
			host_rdata_o <= nxt_host_rdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			proc_rdata_o <= 8'h00;
		end else if (ce_i && proc_rd_i) begin
			proc_rdata_o <= nxt_proc_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// transmitter timer: the host sees holding-empty only after the delay, clears at once
	logic [15:0] delay_cnt_ff;
	logic        tx_holding_empty_host_ff;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			delay_cnt_ff <= 16'h0000;
		end else if (ce_i) begin
			if (!tx_holding_empty_shadow_i || tx_holding_empty_host_ff) begin
				delay_cnt_ff <= 16'h0000;
			end else if (delay_cnt_ff != DELAY_LAST) begin
				delay_cnt_ff <= delay_cnt_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_holding_empty_host_ff <= 1'b1;
		end else if (ce_i) begin
			if (!tx_holding_empty_shadow_i) begin
				tx_holding_empty_host_ff <= 1'b0;
			end else if (!tx_timer_en_i || delay_cnt_ff == DELAY_LAST) begin
				tx_holding_empty_host_ff <= 1'b1;
			end
		end
	end

	assign tx_holding_empty_o = tx_holding_empty_host_ff;

	////////////////////////////////////////////////////////////////////////////////////////////
	// host ready pins and processor request steering
	logic tx_proc_cond;
	logic rx_proc_cond;

	// timer off: the host-visible bit, which trails the shadow by one edge only
	assign tx_proc_cond = tx_timer_en_i ? tx_holding_empty_shadow_i : tx_holding_empty_host_ff;
	assign rx_proc_cond = rx_timer_en_i ? rx_data_ready_shadow_i : rx_data_ready_i;

	assign host_tx_ready_n_o = tx_en ? !tx_holding_empty_host_ff : 1'b1;
	assign host_rx_ready_n_o = rx_en ? !rx_data_ready_i : 1'b1;

	// with both enabled the two sides never share a request; the swap bit exchanges request 0 and request 1
	always_comb begin
		proc_dma_request_0_n_o = proc_dma_request_0_n_i;
		proc_dma_request_1_n_o = proc_dma_request_1_n_i;
		if (rx_en && !swap) begin
			proc_dma_request_0_n_o = !rx_proc_cond;
		end
		if (rx_en && swap) begin
			proc_dma_request_1_n_o = !rx_proc_cond;
		end
		if (tx_en && !swap) begin
			proc_dma_request_1_n_o = !tx_proc_cond;
		end
		if (tx_en && swap) begin
			proc_dma_request_0_n_o = !tx_proc_cond;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// host dma request lines
	logic rx_multi_ff;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_multi_ff <= 1'b0;
		end else if (ce_i) begin
			if (fifo_status_i.rx_empty) begin
				rx_multi_ff <= 1'b0;
			end else if (fifo_status_i.rx_at_trigger) begin
				rx_multi_ff <= 1'b1;
			end
		end
	end

	always_comb begin
		if (multi_mode) begin
			host_rx_dma_req_o = rx_en && (rx_multi_ff || fifo_status_i.rx_at_trigger);
			host_tx_dma_req_o = tx_en && !fifo_status_i.tx_full;
		end else begin
			host_rx_dma_req_o = rx_en && !fifo_status_i.rx_empty;
			host_tx_dma_req_o = tx_en && fifo_status_i.tx_empty;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	chk_scratch_roundtrip: assert property (
		ce_i && host_wr_i && host_scratch |=> scratch_ff == $past(host_wdata_i))
		else $error("scratch write lost");

	chk_scratch_no_irq: assert property (
		ce_i && host_wr_i && !host_div_low && !host_div_high |=> !divisor_irq_o)
		else $error("interrupt on non-divisor write");

	chk_div_low_read: assert property (
		ce_i && proc_rd_i && proc_addr_i == uart_host_dma_pkg::PROC_OFS_DIV_LOW
		|=> proc_rdata_o == $past(div_low_ff))
		else $error("low divisor read mismatch");

	chk_div_high_write: assert property (
		ce_i && host_wr_i && host_div_high
		|=> div_high_ff == $past(host_wdata_i) && divisor_irq_o)
		else $error("high divisor write mishandled");

	chk_div_irq_pulse: assert property (
		ce_i && host_wr_i && host_div_low ##1 ce_i && !host_wr_i
		|=> !divisor_irq_o)
		else $error("divisor interrupt not a pulse");

	chk_tx_ready_pin: assert property (
		tx_en |-> host_tx_ready_n_o == !tx_holding_empty_o)
		else $error("tx ready pin wrong");

	chk_rx_ready_off: assert property (
		!rx_en |-> host_rx_ready_n_o && !host_rx_dma_req_o)
		else $error("rx ready active while disabled");

	chk_rx_ready_pin: assert property (
		rx_en |-> host_rx_ready_n_o == !rx_data_ready_i)
		else $error("rx ready pin wrong");

	chk_req0_tx_swap: assert property (
		tx_en && swap |-> proc_dma_request_0_n_o == !tx_proc_cond)
		else $error("request 0 not from holding empty");

	chk_req1_rx_swap: assert property (
		rx_en && swap |-> proc_dma_request_1_n_o == !rx_proc_cond)
		else $error("request 1 not from data ready");

	chk_req1_tx: assert property (
		tx_en && !swap |-> proc_dma_request_1_n_o == !tx_proc_cond)
		else $error("request 1 not from holding empty");

	chk_req0_rx: assert property (
		rx_en && !swap && !tx_en |-> proc_dma_request_0_n_o == !rx_proc_cond)
		else $error("request 0 not from data ready");

	chk_req_pass: assert property (
		!tx_en && !rx_en |-> proc_dma_request_0_n_o == proc_dma_request_0_n_i
			&& proc_dma_request_1_n_o == proc_dma_request_1_n_i)
		else $error("request pins not passed through");

	chk_tx_holding_empty_delay: assert property (
		ce_i && tx_timer_en_i && !tx_holding_empty_shadow_i
		##1 (ce_i && tx_timer_en_i && tx_holding_empty_shadow_i)[*2]
		|-> !tx_holding_empty_o || TX_DELAY < 2)
		else $error("host holding empty set too early");

	chk_multi_rx: assert property (
		ce_i && multi_mode && rx_en && fifo_status_i.rx_at_trigger && !fifo_status_i.rx_empty
		##1 multi_mode && rx_en && !fifo_status_i.rx_empty |-> host_rx_dma_req_o)
		else $error("multi receive request dropped before empty");

	chk_single_tx: assert property (
		!multi_mode && tx_en |-> host_tx_dma_req_o == fifo_status_i.tx_empty)
		else $error("single transmit request wrong");

endmodule // uart_host_dma

/* File: host_bus_model.sv */
// Purpose: host expansion bus master that drives the emulated uart offsets
// Assumes: strobes change at the falling edge and last one cycle each
// Notes:   a released bus shows the inverse of the last value
`timescale 1ns/100ps

module host_bus_model (
	// clock
	input  wire logic       clk_i,
	// host bus
	input  wire logic [7:0] rdata_i,
	output logic      [2:0] addr_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] wdata_o
);
	initial begin
		addr_o = 3'h2;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// inverse after release so a stale offset or byte never looks valid
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	// read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		d = rdata_i;
		rd_o = 1'b0;
		addr_o = ~a;
	endtask
endmodule // host_bus_model

/* File: tb_top.sv */
// Purpose: self-checking bench for the host register and dma request block
// Assumes: inputs change at the falling edge, transmit timer shortened to 2
// Notes:   steering is swept over all combinations of the swap, receive and transmit enable bits
`timescale 1ns/100ps

module tb_top;
	localparam int DLY = 2;
	logic       clk_i, reset_i, hw, hr, pr, irq, hit, uacc, ths, tte, dr, drs, rte;
	logic       theo, txr_n, rxr_n, txq, rxq, p0i, p1i, p0o, p1o, ce;
	logic [2:0] ha;
	logic [7:0] hwd, hrd, prd, lcr, mcr, fifo_control_reg, pa, v;
	uart_host_dma_pkg::fifo_status_type fs;
	int         error_cnt, n_compared;

	uart_host_dma #(.TX_DELAY(DLY)) uart_host_dma_i (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
		.host_addr_i(ha), .host_wr_i(hw), .host_rd_i(hr), .host_wdata_i(hwd),
		.host_rdata_o(hrd), .host_hit_o(hit), .host_uart_access_o(uacc),
		.line_control_i(lcr), .master_control_i(mcr), .fifo_control_reg_i(fifo_control_reg),
		.proc_addr_i(pa), .proc_rd_i(pr), .proc_rdata_o(prd), .divisor_irq_o(irq),
		.tx_holding_empty_shadow_i(ths), .tx_timer_en_i(tte), .rx_data_ready_i(dr),
		.rx_data_ready_shadow_i(drs), .rx_timer_en_i(rte), .fifo_status_i(fs),
		.tx_holding_empty_o(theo), .host_tx_ready_n_o(txr_n), .host_rx_ready_n_o(rxr_n),
		.host_tx_dma_req_o(txq), .host_rx_dma_req_o(rxq),
		.proc_dma_request_0_n_i(p0i), .proc_dma_request_1_n_i(p1i),
		.proc_dma_request_0_n_o(p0o), .proc_dma_request_1_n_o(p1o));

	host_bus_model host_bus_model_i (
		.clk_i(clk_i), .rdata_i(hrd), .addr_o(ha), .wr_o(hw), .rd_o(hr), .wdata_o(hwd));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic s);
		chk8(nm, {7'h00, e}, {7'h00, s});
	endtask

	task automatic prd_get(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		pa = a;
		pr = 1'b1;
		@(negedge clk_i);
		d = prd;
		pr = 1'b0;
	endtask

	task automatic give_verdict;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// expected {tx ready, rx ready, tx req, rx req, req0, req1}, tx empty set, rx source off
	function automatic logic [7:0] steer(input logic [7:0] m, input logic p);
		logic r0, r1;
		r0 = (m[5] & m[3]) ? 1'b0 : (m[4] & !m[3]) ? 1'b1 : p;
		r1 = (m[5] & !m[3]) ? 1'b0 : (m[4] & m[3]) ? 1'b1 : p;
		return {2'h0, !m[5], 1'b1, m[5], m[4], r0, r1};
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100us;
		error_cnt++;
		give_verdict();
	end

	initial begin
		reset_i = 1'b1;
		ce = 1'b1;
		pr = 1'b0;
		pa = 8'h00;
		lcr = 8'h80;
		mcr = 8'h00;
		fifo_control_reg = 8'h00;
		ths = 1'b1;
		tte = 1'b0;
		dr = 1'b0;
		drs = 1'b0;
		rte = 1'b0;
		fs = 4'b1000;
		p0i = 1'b1;
		p1i = 1'b1;
		error_cnt = 0;
		n_compared = 0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		reset_i = 1'b0;
		for (int i = 7; i < 10; i++) begin
			prd_get(8'hf0 + 8'(i), v);
			chk8("proc reset value", 8'h00, v);
		end
		host_bus_model_i.wr(3'h7, 8'ha5);
		chk1("irq on scratch", 1'b0, irq);
		host_bus_model_i.wr(3'h0, 8'h3c);
		chk1("irq on low", 1'b1, irq);
		@(negedge clk_i);
		chk1("irq one cycle", 1'b0, irq);
		host_bus_model_i.wr(3'h1, 8'hc3);
		chk1("irq on high", 1'b1, irq);
		prd_get(8'hf7, v);
		chk8("proc scratch", 8'ha5, v);
		prd_get(8'hf8, v);
		chk8("proc div low", 8'h3c, v);
		prd_get(8'hf9, v);
		chk8("proc div high", 8'hc3, v);
		host_bus_model_i.rd(3'h1, v);
		chk8("host div high", 8'hc3, v);
		host_bus_model_i.rd(3'h7, v);
		chk8("host scratch", 8'ha5, v);
		ce = 1'b0;
		host_bus_model_i.wr(3'h7, 8'h11);
		ce = 1'b1;
		host_bus_model_i.rd(3'h7, v);
		chk8("scratch frozen", 8'ha5, v);
		#1;
		chk8("offset 0 divisor", 8'h02, {6'h00, hit, uacc});
		lcr = 8'h00;
		#1;
		chk8("offset 0 uart", 8'h01, {6'h00, hit, uacc});
		host_bus_model_i.wr(3'h0, 8'h55);
		chk1("irq access clear", 1'b0, irq);
		host_bus_model_i.rd(3'h0, v);
		chk8("host offset 0 refused", 8'h00, v);
		prd_get(8'hf8, v);
		chk8("div low kept", 8'h3c, v);
		// every swap, receive and transmit enable combination, pins both high then both low
		for (int i = 0; i < 16; i++) begin
			@(negedge clk_i);
			mcr = {2'h0, 3'(i), 3'h0};
			p0i = !i[3];
			p1i = !i[3];
			#1;
			v = steer(mcr, p0i);
			chk8("steer host", v >> 2, {4'h0, txr_n, rxr_n, txq, rxq});
			chk8("steer pins", v & 8'h03, {6'h00, p0o, p1o});
		end
		// timers on: processor follows shadows, host sees the delayed bit
		mcr = 8'h30;
		rte = 1'b1;
		dr = 1'b1;
		p0i = 1'b0;
		p1i = 1'b0;
		tte = 1'b1;
		ths = 1'b0;
		repeat (2) @(negedge clk_i);
		ths = 1'b1;
		#1;
		chk1("req1 tx shadow", 1'b0, p1o);
		chk1("req0 rx shadow", 1'b1, p0o);
		chk1("host rx ready", 1'b0, rxr_n);
		@(negedge clk_i);
		chk1("tx ready delayed", 1'b1, txr_n);
		chk1("host empty delayed", 1'b0, theo);
		@(negedge clk_i);
		chk1("tx ready late", 1'b0, txr_n);
		fifo_control_reg = 8'h08;
		fs = 4'b0010;
		@(negedge clk_i);
		chk8("multi idle", 8'h02, {6'h00, txq, rxq});
		fs = 4'b0001;
		@(negedge clk_i);
		chk1("multi rx trigger", 1'b1, rxq);
		fs = 4'b0000;
		@(negedge clk_i);
		chk1("multi rx held", 1'b1, rxq);
		fs = 4'b0110;
		@(negedge clk_i);
		chk8("multi full empty", 8'h00, {6'h00, txq, rxq});
		fifo_control_reg = 8'h00;
		fs = 4'b0000;
		#1;
		chk8("single mode", 8'h01, {6'h00, txq, rxq});
		give_verdict();
	end
endmodule // tb_top
